// ===== rtl/pmhc_map.svh
// Offsets, field positions, reset values and timing counts for the loop mode controller.
// Assumes one 25 MHz clock and a plain strobe register port.
`ifndef PMHC_MAP_SVH
`define PMHC_MAP_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PMHC_CTRL_OFS 8'h00
`define PMHC_BW_OFS 8'h04
`define PMHC_FBW_OFS 8'h08
`define PMHC_HOLD_OFS 8'h0c
`define PMHC_STEP_OFS 8'h10
`define PMHC_STEP_CMD_OFS 8'h14
`define PMHC_REF_OFS 8'h18
`define PMHC_STAT_OFS 8'h1c
`define PMHC_FREQ_OFS 8'h20
// ****************************************
// Control register fields
// ****************************************
`define PMHC_CTRL_HARD 0
`define PMHC_CTRL_SOFT 1
`define PMHC_CTRL_FAST 2
`define PMHC_CTRL_STEP 3
// ****************************************
// Bandwidth codes: 0 = 0.1 Hz, max = 4 kHz
// ****************************************
`define PMHC_BW_MAX 8'h10
`define PMHC_FBW_MIN 8'h0a
`define PMHC_BW_RST 8'h04
`define PMHC_FBW_RST 8'h0c
// ****************************************
// Reference trim in ppm, predivider
// ****************************************
`define PMHC_TRIM_MAX 16'sd200
`define PMHC_PDIV_MAX 8'h08
// ****************************************
// Timing
// ****************************************
`define PMHC_CLK_HZ 25000000
`define PMHC_HIST_S 120
`define PMHC_INIT_CYC 64
`define PMHC_ACQ_CYC 32
`endif

// ===== rtl/pmhc_pkg.sv
// Types shared by the loop mode controller.
// Assumes the map header is on the include path.
`default_nettype none
package pmhc_pkg;
   // Loop modes
   typedef enum logic [2:0] {
      PMHC_INIT = 3'b000,
      PMHC_FREE = 3'b001,
      PMHC_ACQ = 3'b010,
      PMHC_LOCK = 3'b011,
      PMHC_HOLD = 3'b100
   } pmhc_mode_t;
   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pmhc_req_t;
   // Configuration image
   typedef struct packed {
      logic fast_en;
      logic step_en;
      logic [7:0] bw;
      logic [7:0] fbw;
      logic [7:0] win;
      logic [7:0] dly;
      logic [31:0] step;
      logic [15:0] trim;
      logic ext_sel;
      logic [7:0] pdiv;
   } pmhc_cfg_t;
endpackage
`default_nettype wire

// ===== rtl/pmhc_top.sv
// Loop mode and holdover controller of a jitter-cleaning clock synthesizer.
// Assumes synchronous pins, a register port, and an NVM image on a port.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`default_nettype none
`include "pmhc_map.svh"
module pmhc_top #(
   parameter int NOUT = 4,
   parameter int HDEPTH = 64,
   parameter int SAMPLE_CYC = `PMHC_CLK_HZ,
   parameter int INIT_CYC = `PMHC_INIT_CYC,
   parameter int ACQ_CYC = `PMHC_ACQ_CYC
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hard_rst_pin_b,
   input wire pmhc_pkg::pmhc_req_t req,
   output logic [31:0] rdata,
   input wire pmhc_pkg::pmhc_cfg_t nvm_image,
   input wire logic [3:0] in_valid,
   input wire logic [1:0] in_sel,
   input wire logic [31:0] in_freq,
   input wire logic freq_step_up,
   input wire logic freq_step_down,
   input wire logic [NOUT-1:0] pin_step_mask,
   output logic clk_out_en,
   output logic lock_loss_flag,
   output logic fast_bw_active,
   output logic [7:0] loop_bw,
   output logic [31:0] dco_freq,
   output logic [NOUT*32-1:0] div_freq,
   output logic xtal_cap_en,
   output logic ext_ref_sel,
   output logic [7:0] ref_pdiv,
   output logic [15:0] ref_trim,
   output logic [2:0] loop_mode
);
   import pmhc_pkg::*;

   // ****************************************
   // Reset and initialization
   // ****************************************
   localparam int HIST_SAMPLES = `PMHC_HIST_S;
   logic init_done_ff;
   logic [15:0] init_cnt_ff;
   logic hard_req_ff;
   logic soft_req_ff;
   pmhc_cfg_t cfg_ff;
   pmhc_cfg_t act_ff;
   pmhc_mode_t mode_ff;
   pmhc_mode_t nxt_mode;
   wire hard_go = hard_req_ff | ~hard_rst_pin_b;
   wire wr_ok = req.wr & init_done_ff;
   wire rd_ok = req.rd & init_done_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         init_cnt_ff <= 16'h0000;
         init_done_ff <= 1'b0;
      end else if (hard_go) begin
         init_cnt_ff <= 16'h0000;
         init_done_ff <= 1'b0;
      end else if (!init_done_ff) begin
         init_cnt_ff <= init_cnt_ff + 16'h0001;
         init_done_ff <= (init_cnt_ff == 16'(INIT_CYC - 1));
      end
   end

   // ****************************************
   // Register writes
   // ****************************************
   wire sel_ctrl = wr_ok & (req.addr == `PMHC_CTRL_OFS);
   wire sel_bw = wr_ok & (req.addr == `PMHC_BW_OFS);
   wire sel_fbw = wr_ok & (req.addr == `PMHC_FBW_OFS);
   wire sel_hold = wr_ok & (req.addr == `PMHC_HOLD_OFS);
   wire sel_step = wr_ok & (req.addr == `PMHC_STEP_OFS);
   wire sel_cmd = wr_ok & (req.addr == `PMHC_STEP_CMD_OFS);
   wire sel_ref = wr_ok & (req.addr == `PMHC_REF_OFS);
   wire [7:0] wb = req.wdata[7:0];
   wire [7:0] bw_cl = (wb > `PMHC_BW_MAX) ? `PMHC_BW_MAX : wb;
   wire [7:0] fbw_cl = (wb < `PMHC_FBW_MIN) ? `PMHC_FBW_MIN : bw_cl;
   wire signed [15:0] tr = req.wdata[15:0];
   wire signed [15:0] tr_cl = (tr > `PMHC_TRIM_MAX) ? `PMHC_TRIM_MAX :
                              (tr < -`PMHC_TRIM_MAX) ? -`PMHC_TRIM_MAX : tr;
   wire [7:0] pd_in = req.wdata[31:24];
   wire [7:0] pd_cl = (pd_in == 8'h00) ? 8'h01 :
                      (pd_in > `PMHC_PDIV_MAX) ? `PMHC_PDIV_MAX : pd_in;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_ff <= '0;
         hard_req_ff <= 1'b0;
         soft_req_ff <= 1'b0;
      end else if (hard_go | !init_done_ff) begin
         cfg_ff <= nvm_image;
         hard_req_ff <= 1'b0;
         soft_req_ff <= 1'b0;
      end else begin
         hard_req_ff <= sel_ctrl & req.wdata[`PMHC_CTRL_HARD];
         soft_req_ff <= sel_ctrl & req.wdata[`PMHC_CTRL_SOFT];
         if (sel_ctrl) begin
            cfg_ff.fast_en <= req.wdata[`PMHC_CTRL_FAST];
            cfg_ff.step_en <= req.wdata[`PMHC_CTRL_STEP];
         end
         if (sel_bw) cfg_ff.bw <= bw_cl;
         if (sel_fbw) cfg_ff.fbw <= fbw_cl;
         if (sel_hold) begin
            cfg_ff.win <= req.wdata[7:0];
            cfg_ff.dly <= req.wdata[15:8];
         end
         if (sel_step) cfg_ff.step <= req.wdata;
         if (sel_ref) begin
            cfg_ff.trim <= tr_cl;
            cfg_ff.ext_sel <= req.wdata[16];
            cfg_ff.pdiv <= pd_cl;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         act_ff <= '0;
      end else if (!init_done_ff | soft_req_ff) begin
         act_ff <= cfg_ff;
      end
   end

   // ****************************************
   // Loop mode machine
   // ****************************************
   logic [15:0] acq_cnt_ff;
   wire any_valid = |in_valid;
   wire sel_valid = in_valid[in_sel];
   wire acq_done = (acq_cnt_ff == 16'(ACQ_CYC - 1));

   always_comb begin
      nxt_mode = mode_ff;
      unique case (mode_ff)
         PMHC_INIT: if (init_done_ff) nxt_mode = PMHC_FREE;
         PMHC_FREE: if (any_valid) nxt_mode = PMHC_ACQ;
         PMHC_ACQ: begin
            if (!any_valid) nxt_mode = PMHC_HOLD;
            else if (acq_done) nxt_mode = PMHC_LOCK;
         end
         PMHC_LOCK: begin
            if (!sel_valid && !any_valid) nxt_mode = PMHC_HOLD;
            else if (!sel_valid) nxt_mode = PMHC_ACQ;
         end
         PMHC_HOLD: if (any_valid) nxt_mode = PMHC_ACQ;
         default: nxt_mode = PMHC_INIT;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mode_ff <= PMHC_INIT;
         acq_cnt_ff <= 16'h0000;
      end else if (hard_go | soft_req_ff) begin
         mode_ff <= PMHC_INIT;
         acq_cnt_ff <= 16'h0000;
      end else begin
         mode_ff <= nxt_mode;
         acq_cnt_ff <= (mode_ff == PMHC_ACQ) ? acq_cnt_ff + 16'h0001 : 16'h0000;
      end
   end

   // ****************************************
   // Frequency history and holdover average
   // ****************************************
   logic [31:0] hist_mem [HDEPTH];
   logic [$clog2(HDEPTH)-1:0] wptr_ff;
   logic [31:0] samp_cnt_ff;
   logic [31:0] avg_ff;
   wire samp_tick = (samp_cnt_ff == 32'(SAMPLE_CYC - 1));
   wire locked = (mode_ff == PMHC_LOCK);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         samp_cnt_ff <= 32'h00000000;
         wptr_ff <= '0;
      end else if (!locked || samp_tick) begin
         samp_cnt_ff <= 32'h00000000;
         if (locked) wptr_ff <= wptr_ff + 1'b1;
      end else begin
         samp_cnt_ff <= samp_cnt_ff + 32'h00000001;
      end
   end
   always_ff @(posedge mclk) begin
      if (locked && samp_tick) hist_mem[wptr_ff] <= in_freq;
   end

   logic [39:0] win_sum;
   logic [7:0] win_n;
   always_comb begin
      win_sum = 40'h0000000000;
      win_n = (act_ff.win == 8'h00) ? 8'h01 : act_ff.win;
      for (int i = 0; i < HDEPTH; i++) begin
         if (i < int'(win_n)) begin
            win_sum = win_sum + 40'(hist_mem[wptr_ff - 1'b1 -
                      $clog2(HDEPTH)'(act_ff.dly) - $clog2(HDEPTH)'(i)]);
         end
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) avg_ff <= 32'h00000000;
      else if (locked) avg_ff <= 32'(win_sum / 40'(win_n));
   end

   // ****************************************
   // Oscillator stepping and frequency steering
   // ****************************************
   wire step_ok = act_ff.step_en & ((mode_ff == PMHC_FREE) | locked);
   wire reg_up = sel_cmd & req.wdata[0];
   wire reg_dn = sel_cmd & req.wdata[1];
   wire [NOUT-1:0] reg_mask = req.wdata[8 +: NOUT];

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) dco_freq <= 32'h00000000;
      else if (mode_ff == PMHC_HOLD) dco_freq <= avg_ff;
      else if (mode_ff == PMHC_ACQ || locked) dco_freq <= in_freq;
   end

   for (genvar g = 0; g < NOUT; g++) begin : g_div
      wire up = step_ok & ((freq_step_up & pin_step_mask[g]) | (reg_up & reg_mask[g]));
      wire dn = step_ok & ((freq_step_down & pin_step_mask[g]) | (reg_dn & reg_mask[g]));
      always_ff @(posedge mclk or negedge rst_b) begin
         if (!rst_b) div_freq[g*32 +: 32] <= 32'h00000000;
         else if (!init_done_ff) div_freq[g*32 +: 32] <= 32'h00000000;
         else if (up && !dn) div_freq[g*32 +: 32] <= div_freq[g*32 +: 32] + act_ff.step;
         else if (dn && !up) div_freq[g*32 +: 32] <= div_freq[g*32 +: 32] - act_ff.step;
      end
   end

   // ****************************************
   // Status outputs and read port
   // ****************************************
   logic [31:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 32'h00000000;
      if (rd_ok) begin
         unique case (req.addr)
            `PMHC_CTRL_OFS: nxt_rdata = {28'h0000000, cfg_ff.step_en, cfg_ff.fast_en, 2'b00};
            `PMHC_BW_OFS: nxt_rdata = {24'h000000, cfg_ff.bw};
            `PMHC_FBW_OFS: nxt_rdata = {24'h000000, cfg_ff.fbw};
            `PMHC_HOLD_OFS: nxt_rdata = {16'h0000, cfg_ff.dly, cfg_ff.win};
            `PMHC_STEP_OFS: nxt_rdata = cfg_ff.step;
            `PMHC_REF_OFS: nxt_rdata = {cfg_ff.pdiv, 7'h00, cfg_ff.ext_sel, cfg_ff.trim};
            `PMHC_STAT_OFS: nxt_rdata = {27'h0000000, ~locked, 1'b0, mode_ff};
            `PMHC_FREQ_OFS: nxt_rdata = avg_ff;
            default: nxt_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 32'h00000000;
         clk_out_en <= 1'b0;
         lock_loss_flag <= 1'b1;
         fast_bw_active <= 1'b0;
         loop_bw <= 8'h00;
         xtal_cap_en <= 1'b0;
         ext_ref_sel <= 1'b0;
         ref_pdiv <= 8'h01;
         ref_trim <= 16'h0000;
         loop_mode <= 3'b000;
      end else begin
         rdata <= nxt_rdata;
         clk_out_en <= init_done_ff & (mode_ff != PMHC_INIT);
         lock_loss_flag <= ~locked;
         fast_bw_active <= act_ff.fast_en & (mode_ff == PMHC_ACQ);
         loop_bw <= (act_ff.fast_en && mode_ff == PMHC_ACQ) ? act_ff.fbw : act_ff.bw;
         xtal_cap_en <= ~act_ff.ext_sel;
         ext_ref_sel <= act_ff.ext_sel;
         ref_pdiv <= (act_ff.pdiv == 8'h00) ? 8'h01 : act_ff.pdiv;
         ref_trim <= act_ff.trim;
         loop_mode <= mode_ff;
      end
   end
endmodule
`default_nettype wire

// ===== verif/pmhc_props.sv
// Concurrent checks on the loop mode controller top ports.
// Assumes one clock domain, mclk, with rst_b as its asynchronous reset.
`default_nettype none
module pmhc_props #(
   parameter int NOUT = 4,
   parameter int INIT_CYC = 64
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hard_rst_pin_b,
   input wire pmhc_pkg::pmhc_req_t req,
   input wire logic [31:0] rdata,
   input wire logic [3:0] in_valid,
   input wire logic freq_step_up,
   input wire logic freq_step_down,
   input wire logic clk_out_en,
   input wire logic lock_loss_flag,
   input wire logic fast_bw_active,
   input wire logic [NOUT*32-1:0] div_freq,
   input wire logic xtal_cap_en,
   input wire logic ext_ref_sel,
   input wire logic [2:0] loop_mode
);
   import pmhc_pkg::*;
   // ****************************************
   // Helpers
   // ****************************************
   logic [7:0] init_cnt_ff;
   logic [7:0] nxt_init_cnt;
   wire quiet = hard_rst_pin_b && !req.wr; // No reset source pending
   // Length of one stay in init, restarted by any reset source
   assign nxt_init_cnt = (loop_mode != PMHC_INIT || !quiet) ? 8'h00 : init_cnt_ff + 8'h01;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) init_cnt_ff <= 8'h00;
      else init_cnt_ff <= nxt_init_cnt;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_lock_entry;
      $rose(loop_mode == PMHC_LOCK);
   endsequence
   // ****************************************
   // Assertions
   // ****************************************
   AST_INIT_BOUND: assert property (init_cnt_ff <= INIT_CYC + 3)
      else $error("init stay too long");
   // Clock enable and mode leave the same edge, so they are compared in one cycle
   AST_NO_CLK_INIT: assert property ((loop_mode == PMHC_INIT) |-> !clk_out_en)
      else $error("clock output during init");
   // The mode port lags the machine by one edge, hence two cycles of reaction
   AST_ACQ_START: assert property (quiet && loop_mode == PMHC_FREE && in_valid != 4'h0
      |-> ##2 loop_mode == PMHC_ACQ)
      else $error("no acquisition on valid input");
   AST_FAST_BACK: assert property (s_lock_entry |-> !fast_bw_active)
      else $error("fast bandwidth kept after lock");
   AST_LOL_FLAG: assert property ((loop_mode != PMHC_LOCK) |-> lock_loss_flag)
      else $error("lock loss low while not locked");
   AST_HOLD_IN: assert property (quiet && loop_mode == PMHC_LOCK && in_valid == 4'h0
      |-> ##2 loop_mode == PMHC_HOLD)
      else $error("no holdover entry");
   AST_HOLD_OUT: assert property (quiet && loop_mode == PMHC_HOLD && in_valid != 4'h0
      |-> ##2 loop_mode == PMHC_ACQ)
      else $error("no holdover exit");
   // Mode seen one cycle after the pulse is the one that gated it
   AST_STEP_GATE: assert property (quiet && (freq_step_up || freq_step_down)
      ##1 (loop_mode == PMHC_ACQ || loop_mode == PMHC_HOLD) |-> $stable(div_freq))
      else $error("step applied outside free-run or lock");
   AST_XTAL_CAP: assert property ((loop_mode != PMHC_INIT) |-> xtal_cap_en != ext_ref_sel)
      else $error("load caps not opposite to reference select");
   AST_RD_IDLE: assert property (!req.rd |=> rdata == 32'h0)
      else $error("read data without read strobe");
endmodule
bind pmhc_top pmhc_props #(.NOUT(NOUT), .INIT_CYC(INIT_CYC)) u_props (.mclk(mclk), .rst_b(rst_b),
   .hard_rst_pin_b(hard_rst_pin_b), .req(req), .rdata(rdata), .in_valid(in_valid),
   .freq_step_up(freq_step_up), .freq_step_down(freq_step_down), .clk_out_en(clk_out_en),
   .lock_loss_flag(lock_loss_flag), .fast_bw_active(fast_bw_active), .div_freq(div_freq),
   .xtal_cap_en(xtal_cap_en), .ext_ref_sel(ext_ref_sel), .loop_mode(loop_mode));
`default_nettype wire

// ===== verif/pmhc_ref_model.sv
// Model of the input clocks: validity levels and measured frequency word.
// Assumes the bench sets the wanted levels; changes land after a rising edge.
`default_nettype none
module pmhc_ref_model (
   input wire logic mclk,
   input wire logic [3:0] want_valid,
   input wire logic [31:0] want_freq,
   output logic [3:0] in_valid,
   output logic [31:0] in_freq
);
   // ****************************************
   // Input clock behaviour
   // ****************************************
   initial begin
      in_valid = 4'h0;
      in_freq = 32'h0;
   end
   // Inputs appear and vanish
   // Without a valid input the measurement is junk, so it toggles every cycle
   always @(posedge mclk) begin
      in_valid <= want_valid;
      in_freq <= (want_valid != 4'h0) ? want_freq : ~in_freq;
   end
endmodule
`default_nettype wire

// ===== verif/pmhc_top_tb.sv
// Self-checking bench of the loop mode controller.
// Assumes the input clock model beside it and the map header on the include path.
`default_nettype none
`include "pmhc_map.svh"
module pmhc_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import pmhc_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, hard_b = 1'b1, up = 1'b0, dn = 1'b0;
   logic [3:0] pmask = 4'h0, want_valid = 4'h0, in_valid;
   logic [1:0] in_sel = 2'b00;
   logic [31:0] want_freq = 32'h0, in_freq, rdata, dco_freq, d;
   pmhc_req_t req = '0;
   pmhc_cfg_t nvm = '{1'b0, 1'b0, 8'h05, 8'h0c, 8'h01, 8'h00, 32'h0, 16'h0, 1'b0, 8'h01};
   logic clk_out_en, lock_loss_flag, fast_bw_active, xtal_cap_en, ext_ref_sel;
   logic [7:0] loop_bw, ref_pdiv;
   logic [15:0] ref_trim;
   logic [2:0] loop_mode;
   logic [127:0] div_freq;
   int miscompares = 0, num_checks = 0, cyc = 0;
   pmhc_ref_model refs (.mclk(mclk), .want_valid(want_valid), .want_freq(want_freq),
      .in_valid(in_valid), .in_freq(in_freq));
   pmhc_top #(.SAMPLE_CYC(4)) uut (.mclk(mclk), .rst_b(rst_b), .hard_rst_pin_b(hard_b),
      .req(req), .rdata(rdata), .nvm_image(nvm), .in_valid(in_valid), .in_sel(in_sel),
      .in_freq(in_freq), .freq_step_up(up), .freq_step_down(dn), .pin_step_mask(pmask),
      .clk_out_en(clk_out_en), .lock_loss_flag(lock_loss_flag), .fast_bw_active(fast_bw_active),
      .loop_bw(loop_bw), .dco_freq(dco_freq), .div_freq(div_freq), .xtal_cap_en(xtal_cap_en),
      .ext_ref_sel(ext_ref_sel), .ref_pdiv(ref_pdiv), .ref_trim(ref_trim), .loop_mode(loop_mode));
   // ****************************************
   // Clock, watchdog and shared tasks
   // ****************************************
   initial begin
      forever #20 mclk = ~mclk;
   end
   // Generous ceiling; the whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (miscompares == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge mclk);
      req <= '{a, w, 1'b1, 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] r);
      @(posedge mclk);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 r = rdata;
   endtask
   task automatic wait_mode(input logic [2:0] m, input int lim);
      int n;
      n = 0;
      while (loop_mode !== m && n < lim) begin
         tick(1);
         n++;
      end
      check(loop_mode, m);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_power_up();
      check({clk_out_en, lock_loss_flag, ref_pdiv}, {2'b01, 8'h01});
      rst_b <= 1'b1;
      tick(2);
      bus_rd(`PMHC_STAT_OFS, d); // Too early: ignored
      check(d, 32'h0);
      check(clk_out_en, 1'b0);
      wait_mode(PMHC_FREE, 80);
      tick(2);
      check(clk_out_en, 1'b1);
      bus_rd(`PMHC_STAT_OFS, d);
      check(d, 32'h11);
      bus_rd(8'h30, d);
      check(d, 32'h0);
   endtask
   task automatic t_config();
      bus_wr(`PMHC_BW_OFS, 32'h20);
      bus_rd(`PMHC_BW_OFS, d);
      check(d, 32'h10);
      bus_wr(`PMHC_FBW_OFS, 32'h01);
      bus_rd(`PMHC_FBW_OFS, d);
      check(d, 32'h0a);
      bus_wr(`PMHC_REF_OFS, 32'h02010064);
      bus_wr(`PMHC_STEP_OFS, 32'h100);
      bus_wr(`PMHC_HOLD_OFS, 32'h0404);
      bus_wr(`PMHC_CTRL_OFS, 32'h0c);
      tick(2);
      check(ext_ref_sel, 1'b0);
      bus_wr(`PMHC_CTRL_OFS, 32'h0e);
      wait_mode(PMHC_INIT, 4);
      wait_mode(PMHC_FREE, 4);
      tick(2);
      check({ext_ref_sel, xtal_cap_en, ref_pdiv}, {2'b10, 8'h02});
      check(ref_trim, 16'h0064);
   endtask
   task automatic t_step();
      @(posedge mclk);
      up <= 1'b1;
      pmask <= 4'b0101;
      @(posedge mclk);
      up <= 1'b0;
      tick(2);
      check(div_freq, {32'h0, 32'h100, 32'h0, 32'h100});
      bus_wr(`PMHC_STEP_CMD_OFS, 32'h0202);
      tick(2);
      check(div_freq, {32'h0, 32'h100, 32'hffffff00, 32'h100});
      @(posedge mclk);
      dn <= 1'b1;
      @(posedge mclk);
      dn <= 1'b0;
      tick(2);
      check(div_freq, {32'h0, 32'h0, 32'hffffff00, 32'h0});
   endtask
   task automatic t_lock_hold();
      want_freq <= 32'h1000;
      want_valid <= 4'b0001;
      wait_mode(PMHC_ACQ, 4);
      @(posedge mclk);
      up <= 1'b1;
      @(posedge mclk);
      up <= 1'b0;
      tick(2);
      check(div_freq, {32'h0, 32'h0, 32'hffffff00, 32'h0});
      check({fast_bw_active, lock_loss_flag, loop_bw}, {2'b11, 8'h0a});
      check(dco_freq, 32'h1000);
      wait_mode(PMHC_LOCK, 40);
      tick(2);
      check({fast_bw_active, lock_loss_flag, loop_bw}, {2'b00, 8'h10});
      bus_rd(`PMHC_STAT_OFS, d);
      check(d, 32'h03);
      tick(40);
      want_freq <= 32'h2000; // Newest samples, hidden by the delay
      tick(8);
      want_valid <= 4'b0000;
      wait_mode(PMHC_HOLD, 4);
      tick(2);
      check(dco_freq, 32'h1000);
      bus_rd(`PMHC_FREQ_OFS, d);
      check(d, 32'h1000);
      in_sel <= 2'b01;
      want_valid <= 4'b0010;
      wait_mode(PMHC_ACQ, 4);
      tick(2);
      check(lock_loss_flag, 1'b1);
   endtask
   task automatic t_hard();
      want_valid <= 4'b0000;
      @(posedge mclk);
      hard_b <= 1'b0;
      tick(3);
      check({loop_mode, clk_out_en}, {PMHC_INIT, 1'b0});
      hard_b <= 1'b1;
      wait_mode(PMHC_FREE, 80);
      tick(2);
      bus_rd(`PMHC_BW_OFS, d);
      check(d, 32'h05);
      check({ext_ref_sel, xtal_cap_en, ref_pdiv}, {2'b01, 8'h01});
      bus_wr(`PMHC_CTRL_OFS, 32'h01);
      tick(2);
      check(loop_mode, PMHC_INIT);
      wait_mode(PMHC_FREE, 80);
   endtask
   initial begin
      tick(3);
      t_power_up();
      t_config();
      t_step();
      t_lock_hold();
      t_hard();
      wrap_up();
   end
endmodule
`default_nettype wire
